// >>> design/dcpd_pkg.sv
// Purpose: Constants for the draw command parameter decoder
// Assumes: 32-bit command dwords from the command stream parser
// Notes:   Function
package dcpd_pkg;
  localparam logic [2:0] DCPD_CMD_TYPE     = 3'h3;
  localparam logic [1:0] DCPD_CMD_SUBTYPE  = 2'h3;
  localparam logic [2:0] DCPD_CMD_OPCODE   = 3'h3;
  localparam logic [7:0] DCPD_CMD_SUBOP    = 8'h00;
  localparam int         DCPD_TYPE_MSB     = 31;
  localparam int         DCPD_TYPE_LSB     = 29;
  localparam int         DCPD_SUBTYPE_MSB  = 28;
  localparam int         DCPD_SUBTYPE_LSB  = 27;
  localparam int         DCPD_OPCODE_MSB   = 26;
  localparam int         DCPD_OPCODE_LSB   = 24;
  localparam int         DCPD_SUBOP_MSB    = 23;
  localparam int         DCPD_SUBOP_LSB    = 16;
  localparam int         DCPD_RANDOM_BIT   = 15;
  localparam int         DCPD_TOPO_MSB     = 14;
  localparam int         DCPD_TOPO_LSB     = 10;
  localparam int         DCPD_INTCNT_BIT   = 9;
  localparam int         DCPD_LEN_MSB      = 7;
  localparam int         DCPD_LEN_LSB      = 0;
  localparam logic [7:0] DCPD_LEN_BIAS     = 8'h02;
  localparam logic [7:0] DCPD_LEN_DEFAULT  = 8'h04;
  localparam logic [2:0] DCPD_DW_COUNT     = 3'h1;
  localparam logic [2:0] DCPD_DW_START     = 3'h2;
  localparam logic [2:0] DCPD_DW_INST      = 3'h3;
  localparam logic [2:0] DCPD_DW_INSTSTART = 3'h4;
  localparam logic [2:0] DCPD_DW_BIAS      = 3'h5;
  localparam logic [4:0] DCPD_TOPO_FIRST   = 5'h01;
  localparam logic [4:0] DCPD_TOPO_LAST    = 5'h14;
  localparam logic [4:0] DCPD_QUAD_LIST    = 5'h07;
  localparam logic [4:0] DCPD_QUAD_STRIP   = 5'h08;
  localparam logic [4:0] DCPD_POLYGON      = 5'h0e;
  localparam logic [4:0] DCPD_LINE_LOOP    = 5'h10;
  localparam logic [4:0] DCPD_LINE_STRIP   = 5'h03;
  localparam logic [4:0] DCPD_TRIFAN_UNST  = 5'h16;

  typedef enum logic [1:0] {
    DCPD_ST_HEADER,
    DCPD_ST_BODY,
    DCPD_ST_SKIP,
    DCPD_ST_ISSUE
  } dcpd_state_t;
endpackage

// >>> design/dcpd_topo_map.sv
// Purpose: Topology code validation and entry conversion
// Assumes: Code taken straight from header bits 14:10
// Notes:   Pure combinational, no state
`timescale 1ns/10ps
module dcpd_topo_map (
  input  wire logic [4:0] code_in,
  output logic      [4:0] mapped_out,
  output logic            valid_out
);
  import dcpd_pkg::*;

  always_comb begin
    valid_out = ((code_in >= DCPD_TOPO_FIRST) && (code_in <= DCPD_TOPO_LAST))
                || (code_in == DCPD_TRIFAN_UNST);
    case (code_in)
      DCPD_QUAD_LIST:  mapped_out = DCPD_POLYGON;
      DCPD_QUAD_STRIP: mapped_out = DCPD_POLYGON;
      DCPD_LINE_LOOP:  mapped_out = DCPD_LINE_STRIP;
      default:         mapped_out = code_in;
    endcase
  end
endmodule

// >>> design/dcpd_decoder.sv
// Purpose: Decodes draw command parameter dwords for vertex fetch
// Assumes: Parser offers one dword per cycle with valid/ready
// Notes:   Buffer-extent zeroing and vertex discard live in fetch
`timescale 1ns/10ps
module dcpd_decoder #(
  parameter int DW = 32
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_in,
  input  wire logic [DW-1:0]        dword_in,
  input  wire logic                 dword_valid_in,
  input  wire logic                 dword_last_in,
  output logic                      dword_ready_out,
  input  wire logic [DW-1:0]        internal_vertex_count_in,
  output logic                      draw_valid_out,
  input  wire logic                 draw_ready_in,
  output logic                      draw_random_out,
  output logic      [4:0]           draw_topology_out,
  output logic      [DW-1:0]        draw_vertex_count_out,
  output logic      [DW-1:0]        draw_start_vertex_out,
  output logic      [DW-1:0]        draw_instance_count_out,
  output logic      [DW-1:0]        draw_start_instance_out,
  output logic      [DW-1:0]        draw_base_vertex_out,
  output logic                      cmd_mismatch_out,
  output logic                      noop_pulse_out
);
  import dcpd_pkg::*;

  if (DW != 32) begin : g_bad_width
    $error("dcpd_decoder serves only 32-bit dwords");
  end

  dcpd_state_t     state_r;
  logic [8:0]      remain_r;
  logic [2:0]      index_r;
  logic            random_r;
  logic            intcnt_r;
  logic [4:0]      topo_r;
  logic            topo_ok_r;
  logic [DW-1:0]   vcount_r;
  logic [DW-1:0]   start_r;
  logic [DW-1:0]   inst_r;
  logic [DW-1:0]   inst_start_r;
  logic [DW-1:0]   bias_r;
  logic            noop_r;
  logic            mismatch_r;
  logic            is_draw;
  logic [4:0]      topo_mapped;
  logic            topo_valid;
  logic            take;
  logic            drop_cmd;
  logic [DW-1:0]   eff_count;
  logic [DW-1:0]   vcount_nxt;
  logic [DW-1:0]   start_nxt;
  logic [DW-1:0]   inst_nxt;
  logic [DW-1:0]   inst_start_nxt;
  logic [DW-1:0]   bias_nxt;

  dcpd_topo_map u_topo (
    .code_in    (dword_in[DCPD_TOPO_MSB:DCPD_TOPO_LSB]),
    .mapped_out (topo_mapped),
    .valid_out  (topo_valid)
  );

  assign is_draw =
    (dword_in[DCPD_TYPE_MSB:DCPD_TYPE_LSB] == DCPD_CMD_TYPE) &&
    (dword_in[DCPD_SUBTYPE_MSB:DCPD_SUBTYPE_LSB] == DCPD_CMD_SUBTYPE) &&
    (dword_in[DCPD_OPCODE_MSB:DCPD_OPCODE_LSB] == DCPD_CMD_OPCODE) &&
    (dword_in[DCPD_SUBOP_MSB:DCPD_SUBOP_LSB] == DCPD_CMD_SUBOP);

  // The parser is stalled only in issue, while a command awaits fetch or is being dropped
  assign dword_ready_out = (state_r != DCPD_ST_ISSUE);
  assign take = dword_valid_in && dword_ready_out;

  // Count chosen once the count dword is known; internal count wins
  assign eff_count = intcnt_r ? internal_vertex_count_in : vcount_nxt;

  // Zero count, zero instances or reserved topology issue nothing;
  // judged on the held copies so the verdict cannot move while waiting
  assign drop_cmd = (draw_vertex_count_out == '0) ||
                    (draw_instance_count_out == '0) || !topo_ok_r;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= DCPD_ST_HEADER;
    end else begin
      case (state_r)
        DCPD_ST_HEADER: begin
          if (take && is_draw && !dword_last_in) begin
            state_r <= DCPD_ST_BODY;
          end else if (take && !is_draw && !dword_last_in) begin
            state_r <= DCPD_ST_SKIP;
          end
        end
        DCPD_ST_BODY: begin
          // Length field or the last flag, whichever comes first, tells where the packet ends
          if (take && (remain_r == 9'h001 || dword_last_in)) begin
            state_r <= DCPD_ST_ISSUE;
          end
        end
        DCPD_ST_SKIP: begin
          if (take && dword_last_in) begin
            state_r <= DCPD_ST_HEADER;
          end
        end
        DCPD_ST_ISSUE: begin
          if (drop_cmd || draw_ready_in) begin
            state_r <= DCPD_ST_HEADER;
          end
        end
        default: state_r <= DCPD_ST_HEADER;
      endcase
    end
  end

  // Header fields and dword counter
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      remain_r  <= {1'b0, DCPD_LEN_DEFAULT + DCPD_LEN_BIAS - 8'h01};
      index_r   <= 3'h0;
      random_r  <= 1'b0;
      intcnt_r  <= 1'b0;
      topo_r    <= 5'h00;
      topo_ok_r <= 1'b0;
    end else if (take && state_r == DCPD_ST_HEADER && is_draw) begin
      // Dwords after the header equal length field plus one
      // Nine bits, so a full length field does not wrap to zero
      remain_r  <= {1'b0, dword_in[DCPD_LEN_MSB:DCPD_LEN_LSB]} + 9'h001;
      index_r   <= DCPD_DW_COUNT;
      random_r  <= dword_in[DCPD_RANDOM_BIT];
      intcnt_r  <= dword_in[DCPD_INTCNT_BIT];
      topo_r    <= topo_mapped;
      topo_ok_r <= topo_valid;
    end else if (take && state_r == DCPD_ST_BODY) begin
      remain_r <= remain_r - 9'h001;
      if (index_r <= DCPD_DW_BIAS) begin
        index_r <= index_r + 3'h1;
      end
    end
  end

  // Parameter dwords; missing trailing dwords read as zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vcount_r     <= '0;
      start_r      <= '0;
      inst_r       <= '0;
      inst_start_r <= '0;
      bias_r       <= '0;
    end else if (take && state_r == DCPD_ST_HEADER && is_draw) begin
      vcount_r     <= '0;
      start_r      <= '0;
      inst_r       <= '0;
      inst_start_r <= '0;
      bias_r       <= '0;
    end else if (take && state_r == DCPD_ST_BODY) begin
      case (index_r)
        DCPD_DW_COUNT:     vcount_r     <= dword_in;
        DCPD_DW_START:     start_r      <= dword_in;
        DCPD_DW_INST:      inst_r       <= dword_in;
        DCPD_DW_INSTSTART: inst_start_r <= dword_in;
        DCPD_DW_BIAS:      bias_r       <= dword_in;
        default:           ;
      endcase
    end
  end

  // Values as they stand after this edge, so the final body dword
  // reaches the outputs on the same edge that enters issue
  always_comb begin
    vcount_nxt     = vcount_r;
    start_nxt      = start_r;
    inst_nxt       = inst_r;
    inst_start_nxt = inst_start_r;
    bias_nxt       = bias_r;
    if (take && state_r == DCPD_ST_BODY) begin
      case (index_r)
        DCPD_DW_COUNT:     vcount_nxt     = dword_in;
        DCPD_DW_START:     start_nxt      = dword_in;
        DCPD_DW_INST:      inst_nxt       = dword_in;
        DCPD_DW_INSTSTART: inst_start_nxt = dword_in;
        DCPD_DW_BIAS:      bias_nxt       = dword_in;
        default:           ;
      endcase
    end
  end

  // Registered copies handed to vertex fetch
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      draw_random_out         <= 1'b0;
      draw_topology_out       <= 5'h00;
      draw_vertex_count_out   <= '0;
      draw_start_vertex_out   <= '0;
      draw_instance_count_out <= '0;
      draw_start_instance_out <= '0;
      draw_base_vertex_out    <= '0;
    end else if (state_r == DCPD_ST_BODY) begin
      // Updated only before issue so they hold while waiting
      draw_random_out         <= random_r;
      draw_topology_out       <= topo_r;
      draw_vertex_count_out   <= eff_count;
      draw_start_vertex_out   <= start_nxt;
      draw_instance_count_out <= inst_nxt;
      draw_start_instance_out <= inst_start_nxt;
      // Bias forced to zero in sequential mode
      draw_base_vertex_out    <= random_r ? bias_nxt : '0;
    end
  end

  // One-cycle status pulses
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mismatch_r <= 1'b0;
      noop_r     <= 1'b0;
    end else begin
      mismatch_r <= take && state_r == DCPD_ST_HEADER && !is_draw;
      noop_r     <= state_r == DCPD_ST_ISSUE && drop_cmd;
    end
  end

  assign cmd_mismatch_out = mismatch_r;
  assign noop_pulse_out   = noop_r;
  // Vertex fetch discards surplus vertices; nothing flagged here
  // Out-of-extent zero data is served by fetch
  assign draw_valid_out   = (state_r == DCPD_ST_ISSUE) && !drop_cmd;

  a_hold_stable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    draw_valid_out && !draw_ready_in |=> draw_valid_out &&
    $stable(draw_vertex_count_out) && $stable(draw_topology_out))
    else $error("draw parameters moved while waiting");

  a_zero_noop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    draw_valid_out |-> draw_vertex_count_out != '0 &&
    draw_instance_count_out != '0)
    else $error("zero count command issued");

  a_seq_bias: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    draw_valid_out && !draw_random_out |-> draw_base_vertex_out == '0)
    else $error("bias used in sequential mode");

  a_topo_legal: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    draw_valid_out |-> draw_topology_out != DCPD_QUAD_LIST &&
    draw_topology_out != DCPD_QUAD_STRIP &&
    draw_topology_out != DCPD_LINE_LOOP && draw_topology_out != 5'h00 &&
    (draw_topology_out <= DCPD_TOPO_LAST ||
     draw_topology_out == DCPD_TRIFAN_UNST))
    else $error("unconverted or reserved topology issued");

  a_intcnt_use: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_r == DCPD_ST_BODY && intcnt_r |=>
    draw_vertex_count_out == $past(internal_vertex_count_in))
    else $error("internal vertex count not used");

  a_header_decode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    take && state_r == DCPD_ST_HEADER &&
    dword_in[DCPD_TYPE_MSB:DCPD_TYPE_LSB] != DCPD_CMD_TYPE |=>
    state_r != DCPD_ST_BODY && cmd_mismatch_out)
    else $error("foreign header accepted");

  a_random_bit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    take && state_r == DCPD_ST_HEADER && is_draw |=>
    random_r == $past(dword_in[DCPD_RANDOM_BIT]))
    else $error("access mode not captured");

  a_length_end: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    take && state_r == DCPD_ST_HEADER && is_draw && !dword_last_in &&
    dword_in[DCPD_LEN_MSB:DCPD_LEN_LSB] == 8'h00 ##1
    take && state_r == DCPD_ST_BODY |=> state_r == DCPD_ST_ISSUE)
    else $error("packet end not found by length");

  a_noop_drop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_r == DCPD_ST_ISSUE && drop_cmd |=>
    state_r == DCPD_ST_HEADER && noop_pulse_out)
    else $error("dropped command not consumed");
endmodule

// >>> testbench/dcpd_parser_model.sv
// Purpose: Command stream parser model feeding packet dwords
// Assumes: An offer is held until a rising edge samples ready high
// Notes:   Released data shows the inverse of the last dword
`timescale 1ns/10ps
module dcpd_parser_model (
  input  wire logic        clk_in,
  input  wire logic        ready_in,
  output logic      [31:0] dword_out,
  output logic             valid_out,
  output logic             last_out
);
  initial begin
    dword_out = 32'h0;
    valid_out = 1'b0;
    last_out  = 1'b0;
  end

  task automatic send(input logic [31:0] d, input logic l);
    @(negedge clk_in);
    dword_out = d;
    valid_out = 1'b1;
    last_out  = l;
    do @(posedge clk_in); while (ready_in !== 1'b1);
  endtask

  // Stale data would hide a decoder that samples without valid
  task automatic idle();
    @(negedge clk_in);
    valid_out = 1'b0;
    last_out  = 1'b0;
    dword_out = ~dword_out;
  endtask
endmodule

// >>> testbench/dcpd_decoder_tb.sv
// Purpose: Self-checking bench for the draw command decoder
// Assumes: Inputs change at falling edges
// Notes:   Each draw is stalled three cycles before acceptance
`timescale 1ns/10ps
module dcpd_decoder_tb;
  import dcpd_pkg::*;
  typedef struct {logic r; logic [4:0] t; logic ic;
                  logic [31:0] c; logic [31:0] n;} dcpd_row_t;
  logic        clk_sys_in    = 1'b0;
  logic        rst_in        = 1'b1;
  logic        draw_ready_in = 1'b0;
  logic [31:0] ivc           = 32'h0000_0123;
  logic [31:0] dw, dcnt, dsv, dinst, dsi, dbv;
  logic        dv, dl, rdy, dval, drnd, mis, nop;
  logic [4:0]  dtop;
  int          miscompares   = 0;
  int          compares      = 0;
  int          k;
  int          mis_seen      = 0;
  dcpd_row_t   rows [15] = '{
    '{1'b0, 5'h04, 1'b0, 32'h6, 32'h1},
    '{1'b1, 5'h0b, 1'b0, 32'hc, 32'h2},
    '{1'b0, 5'h07, 1'b0, 32'h4, 32'h1},
    '{1'b1, 5'h08, 1'b0, 32'h4, 32'h3},
    '{1'b0, 5'h10, 1'b1, 32'h0, 32'h1},
    '{1'b1, 5'h16, 1'b1, 32'h5, 32'h1},
    '{1'b0, 5'h01, 1'b0, 32'h1, 32'hffff_ffff},
    '{1'b1, 5'h14, 1'b0, 32'hffff_ffff, 32'h1},
    '{1'b0, 5'h04, 1'b0, 32'h0, 32'h1},
    '{1'b1, 5'h04, 1'b0, 32'h6, 32'h0},
    '{1'b0, 5'h00, 1'b0, 32'h6, 32'h1},
    '{1'b0, 5'h15, 1'b0, 32'h6, 32'h1},
    '{1'b0, 5'h17, 1'b0, 32'h6, 32'h1},
    '{1'b0, 5'h1f, 1'b0, 32'h6, 32'h1},
    '{1'b0, 5'h0e, 1'b0, 32'h3, 32'h1}};

  always #50 clk_sys_in = ~clk_sys_in;

  // Mismatch is a one-cycle pulse; count it where it stands
  always @(negedge clk_sys_in) begin
    if (mis === 1'b1) begin
      mis_seen++;
    end
  end

  dcpd_parser_model i_parser (.clk_in(clk_sys_in), .ready_in(rdy),
    .dword_out(dw), .valid_out(dv), .last_out(dl));

  dcpd_decoder i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .dword_in(dw), .dword_valid_in(dv), .dword_last_in(dl),
    .dword_ready_out(rdy), .internal_vertex_count_in(ivc),
    .draw_valid_out(dval), .draw_ready_in(draw_ready_in),
    .draw_random_out(drnd), .draw_topology_out(dtop),
    .draw_vertex_count_out(dcnt), .draw_start_vertex_out(dsv),
    .draw_instance_count_out(dinst), .draw_start_instance_out(dsi),
    .draw_base_vertex_out(dbv), .cmd_mismatch_out(mis),
    .noop_pulse_out(nop));

  function automatic logic [4:0] exp_topo(input logic [4:0] t);
    if (t == 5'h07 || t == 5'h08) return 5'h0e;
    if (t == 5'h10) return 5'h03;
    return t;
  endfunction

  task automatic chk_word(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, e, input string m);
    chk_word({31'h0, g}, {31'h0, e}, m);
  endtask

  task automatic wait_out();
    k = 0;
    while (dval !== 1'b1 && nop !== 1'b1 && mis !== 1'b1 && k < 8) begin
      @(negedge clk_sys_in);
      k++;
    end
  endtask

  task automatic run_row(input int i);
    dcpd_row_t   w;
    logic [31:0] ec, s;
    logic        np;
    w  = rows[i];
    s  = 32'(i);
    ec = w.ic ? ivc : w.c;
    np = ec == 0 || w.n == 0 || w.t == 0 || w.t == 5'h15 || w.t > 5'h16;
    i_parser.send({8'h7b, 8'h00, w.r, w.t, w.ic, 9'h004}, 1'b0);
    i_parser.send(w.c, 1'b0);
    i_parser.send(32'h100 + s, 1'b0);
    i_parser.send(w.n, 1'b0);
    i_parser.send(32'h200 + s, 1'b0);
    i_parser.send(32'hffff_fff0, 1'b1);
    i_parser.idle();
    wait_out();
    chk_bit(nop, np, "noop");
    chk_bit(dval, !np, "valid");
    if (dval === 1'b1) begin
      repeat (3) @(negedge clk_sys_in);
      chk_bit(rdy, 1'b0, "ready while held");
      chk_bit(drnd, w.r, "random");
      chk_word({27'h0, dtop}, {27'h0, exp_topo(w.t)}, "topo");
      chk_word(dcnt, ec, "count");
      chk_word(dsv, 32'h100 + s, "start");
      chk_word(dinst, w.n, "instances");
      chk_word(dsi, 32'h200 + s, "start inst");
      chk_word(dbv, w.r ? 32'hffff_fff0 : 32'h0, "bias");
      draw_ready_in = 1'b1;
      @(negedge clk_sys_in);
      draw_ready_in = 1'b0;
      chk_bit(dval, 1'b0, "valid after accept");
    end
    $display("Row %0d done", i);
  endtask

  task automatic stop_test();
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(100 * 3000);
    miscompares++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chk_bit(dval, 1'b0, "reset valid");
    chk_bit(rdy, 1'b1, "reset ready");
    chk_word(dcnt, 32'h0, "reset count");
    $display("Reset test done");
    for (int i = 0; i < 15; i++) begin
      run_row(i);
    end
    // Reset while a command waits must withdraw the offer
    i_parser.send({8'h7b, 8'h00, 1'b1, 5'h04, 1'b0, 9'h004}, 1'b0);
    repeat (4) i_parser.send(32'h0000_0009, 1'b0);
    i_parser.send(32'h0000_0007, 1'b1);
    i_parser.idle();
    wait_out();
    chk_bit(dval, 1'b1, "held before reset");
    chk_word(dbv, 32'h0000_0007, "bias before reset");
    rst_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chk_bit(dval, 1'b0, "valid after reset");
    chk_bit(rdy, 1'b1, "ready after reset");
    chk_word(dbv, 32'h0, "bias after reset");
    $display("Mid reset test done");
    // Length zero ends the packet after one body dword, no last flag
    i_parser.send({8'h7b, 8'h00, 1'b0, 5'h04, 1'b0, 9'h000}, 1'b0);
    i_parser.send(32'h0000_0006, 1'b0);
    i_parser.idle();
    wait_out();
    chk_bit(nop, 1'b1, "short packet dropped");
    chk_bit(dval, 1'b0, "short packet valid");
    chk_bit(rdy, 1'b1, "short packet ready");
    $display("Short packet test done");
    chk_word(32'(mis_seen), 32'h0, "mismatch on draws");
    // Subtype 0 packet and a lone foreign header are both swallowed
    i_parser.send(32'h6300_0004, 1'b0);
    i_parser.send(32'h0000_0006, 1'b1);
    i_parser.send(32'h0200_0000, 1'b1);
    i_parser.idle();
    wait_out();
    repeat (2) @(negedge clk_sys_in);
    chk_word(32'(mis_seen), 32'h2, "mismatch pulses");
    chk_bit(dval, 1'b0, "mismatch valid");
    $display("Mismatch test done");
    stop_test();
  end
endmodule
